/* File: hdl/bstap_map.vh */
// Constants of the boundary-scan test access port
`ifndef BSTAP_MAP_VH
`define BSTAP_MAP_VH

// ****************************************************
// Widths
// ****************************************************
`define BSTAP_IR_W 4
`define BSTAP_NUM_PINS 4
`define BSTAP_CELL_BITS 3
`define BSTAP_BSR_LEN 12
`define BSTAP_ID_W 32

// ****************************************************
// Instruction codes
// ****************************************************
`define BSTAP_OP_EXTEST 4'h0
`define BSTAP_OP_SAMPLE 4'h5
`define BSTAP_OP_IDCODE 4'h6
`define BSTAP_OP_BYPASS 4'hF
`define BSTAP_IR_CAPTURE 4'h1

// ****************************************************
// Identity (arbitrary value, bit 0 set as required)
// ****************************************************
`define BSTAP_IDCODE_VALUE 32'h00000001

// ****************************************************
// Cell bit positions within one element
// ****************************************************
`define BSTAP_CELL_IN 0
`define BSTAP_CELL_OE 1
`define BSTAP_CELL_OUT 2

`endif

/* File: hdl/bstap_cell.v */
// Three-bit boundary-scan element for one user pin
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.vh"

module bstap_cell (
    input wire ref_clk,
    input wire rst_n,
    input wire capture_en,
    input wire shift_en,
    input wire update_en,
    input wire mode_extest,
    input wire sdi,
    input wire core_out,
    input wire core_oe,
    input wire pin_in,
    output wire sdo,
    output wire pin_out,
    output wire pin_oe,
    output wire core_in
);

    reg [2:0] cap;
    reg [2:0] upd;

    // ****************************************************
    // Capture and shift stage
    // ****************************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap <= 3'h0;
        end else if (capture_en) begin
            cap[`BSTAP_CELL_IN] <= pin_in;
            cap[`BSTAP_CELL_OE] <= core_oe;
            cap[`BSTAP_CELL_OUT] <= core_out;
        end else if (shift_en) begin
            cap <= {cap[1:0], sdi};
        end
    end

    // ****************************************************
    // Update stage
    // ****************************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            upd <= 3'h0;
        end else if (update_en) begin
            upd <= cap;
        end
    end

    assign sdo = cap[2];
    assign pin_out = mode_extest ? upd[`BSTAP_CELL_OUT] : core_out;
    assign pin_oe = mode_extest ? upd[`BSTAP_CELL_OE] : core_oe;
    assign core_in = mode_extest ? upd[`BSTAP_CELL_IN] : pin_in;

endmodule // bstap_cell

`default_nettype wire

/* File: hdl/bstap_port.v */
// Boundary-scan test access port: TAP controller, instruction and data registers
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.vh"

module bstap_port (
    input wire ref_clk,
    input wire rstn,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_n,
    output reg tdo,
    output reg tdo_oe,
    input wire config_active,
    input wire [`BSTAP_NUM_PINS-1:0] core_out,
    input wire [`BSTAP_NUM_PINS-1:0] core_oe,
    output wire [`BSTAP_NUM_PINS-1:0] core_in,
    input wire [`BSTAP_NUM_PINS-1:0] pin_in,
    output wire [`BSTAP_NUM_PINS-1:0] pin_out,
    output wire [`BSTAP_NUM_PINS-1:0] pin_oe
);

    localparam NP = `BSTAP_NUM_PINS;

    // ****************************************************
    // TAP states
    // ****************************************************
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PAU_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SH_IR = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PAU_IR = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UPD_IR = 4'hF;

    // ****************************************************
    // Resets
    // ****************************************************
    reg [1:0] rst_sync;
    reg [1:0] tap_rst_sync;
    wire rst_n;
    wire tap_rst_n;
    wire tap_arst_n;

    // System reset asserts at once, releases on the clock
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Test reset clears the scan logic at once, release is synchronous
    assign tap_arst_n = rstn & trst_n;
    always @(posedge ref_clk or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            tap_rst_sync <= 2'h0;
        end else begin
            tap_rst_sync <= {tap_rst_sync[0], 1'b1};
        end
    end
    assign tap_rst_n = tap_rst_sync[1];

    // ****************************************************
    // Pin synchronisers and test clock edges
    // ****************************************************
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg tck_d;
    reg [NP-1:0] pad_s1;
    reg [NP-1:0] pad_s2;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire tck_rise;
    wire tck_fall;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            tck_d <= 1'b0;
            pad_s1 <= {NP{1'b0}};
            pad_s2 <= {NP{1'b0}};
        end else begin
            pin_s1 <= {tck, tms, tdi};
            pin_s2 <= pin_s1;
            tck_d <= pin_s2[2];
            pad_s1 <= pin_in;
            pad_s2 <= pad_s1;
        end
    end
    assign tck_s = pin_s2[2];
    assign tms_s = pin_s2[1];
    assign tdi_s = pin_s2[0];
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // ****************************************************
    // TAP controller
    // ****************************************************
    reg [3:0] state;
    reg [3:0] next_state;

    always @* begin
        case (state)
            ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = tms_s ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = tms_s ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // Mode select and clock steer the controller; test or system reset forces ST_RESET
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ****************************************************
    // Instruction register
    // ****************************************************
    reg [`BSTAP_IR_W-1:0] ir_shift;
    reg [`BSTAP_IR_W-1:0] ir;

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_shift <= `BSTAP_IR_CAPTURE;
        end else if (tck_rise && state == ST_CAP_IR) begin
            ir_shift <= `BSTAP_IR_CAPTURE;
        end else if (tck_rise && state == ST_SH_IR) begin
            ir_shift <= {tdi_s, ir_shift[`BSTAP_IR_W-1:1]};
        end
    end

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir <= `BSTAP_OP_IDCODE;
        end else if (state == ST_RESET) begin
            ir <= `BSTAP_OP_IDCODE;
        end else if (tck_fall && state == ST_UPD_IR) begin
            ir <= ir_shift;
        end
    end

    // ****************************************************
    // Instruction decode
    // ****************************************************
    wire op_extest;
    wire sel_bsr;
    wire sel_id;
    wire sel_byp;

    assign op_extest = (ir == `BSTAP_OP_EXTEST);
    assign sel_bsr = op_extest | (ir == `BSTAP_OP_SAMPLE);
    assign sel_id = (ir == `BSTAP_OP_IDCODE);
    // All ones and every unused code fall back to bypass
    assign sel_byp = ~sel_bsr & ~sel_id;

    wire dr_capture;
    wire dr_shift;
    wire dr_update;

    // Updates land on the fall, one and a half periods after the last shift
    assign dr_capture = tck_rise && state == ST_CAP_DR;
    assign dr_shift = tck_rise && state == ST_SH_DR;
    assign dr_update = tck_fall && state == ST_UPD_DR;

    // ****************************************************
    // Bypass and identity registers
    // ****************************************************
    reg bypass_bit;
    reg [`BSTAP_ID_W-1:0] id_shift;

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bypass_bit <= 1'b0;
            id_shift <= {`BSTAP_ID_W{1'b0}};
        end else begin
            if (sel_byp && dr_capture) begin
                bypass_bit <= 1'b0;
            end else if (sel_byp && dr_shift) begin
                bypass_bit <= tdi_s;
            end
            if (sel_id && dr_capture) begin
                id_shift <= `BSTAP_IDCODE_VALUE;
            end else if (sel_id && dr_shift) begin
                id_shift <= {tdi_s, id_shift[`BSTAP_ID_W-1:1]};
            end
        end
    end

    // ****************************************************
    // Boundary-scan chain
    // ****************************************************
    wire [NP:0] chain;
    wire [NP-1:0] cell_out;
    wire [NP-1:0] cell_oe;

    assign chain[0] = tdi_s;
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_cell
            bstap_cell u_cell (
                .ref_clk(ref_clk),
                .rst_n(tap_rst_n),
                .capture_en(sel_bsr & dr_capture),
                .shift_en(sel_bsr & dr_shift),
                .update_en(sel_bsr & dr_update),
                .mode_extest(op_extest),
                .sdi(chain[gi]),
                .core_out(core_out[gi]),
                .core_oe(core_oe[gi]),
                .pin_in(pad_s2[gi]),
                .sdo(chain[gi+1]),
                .pin_out(cell_out[gi]),
                .pin_oe(cell_oe[gi]),
                .core_in(core_in[gi])
            );
        end
    endgenerate

    assign pin_out = cell_out;
    // Configuration overrides any enable from the chain
    assign pin_oe = config_active ? {NP{1'b0}} : cell_oe;

    // ****************************************************
    // Serial output
    // ****************************************************
    reg dr_bit;

    always @* begin
        if (sel_bsr) begin
            dr_bit = chain[NP];
        end else if (sel_id) begin
            dr_bit = id_shift[0];
        end else begin
            dr_bit = bypass_bit;
        end
    end

    // Tester samples on the rise, so data leaves on the fall
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= (state == ST_SH_IR) ? ir_shift[0] : dr_bit;
            tdo_oe <= (state == ST_SH_IR) || (state == ST_SH_DR);
        end
    end

endmodule // bstap_port

`default_nettype wire

/* File: test/bstap_port_checker.sv */
// Port checker of the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none
module bstap_port_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic config_active,
    input wire logic [3:0] core_out,
    input wire logic [3:0] core_oe,
    input wire logic [3:0] core_in,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe
);
    logic tck_q;
    logic [3:0] fall_age;
    // Cycles since the test clock pin last fell
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tck_q <= 1'b0;
            fall_age <= 4'hF;
        end else begin
            tck_q <= tck;
            if (tck_q && !tck) begin
                fall_age <= 4'h0;
            end else if (fall_age != 4'hF) begin
                fall_age <= fall_age + 4'h1;
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence after_fall; fall_age <= 4'h5; endsequence
    sequence held_reset; (!trst_n) [*2]; endsequence
    sequence tck_still; $stable(tck) [*6]; endsequence
    sequence pins_still; (!trst_n && $stable(pin_in)) [*4]; endsequence
    a_cfg_pins_float: assert property (config_active |-> pin_oe == 4'h0)
        else $error("pin enable while configuring");
    a_trst_clears_tap: assert property ($fell(trst_n) |-> !tdo_oe && !tdo)
        else $error("test reset did not clear at once");
    a_reset_stays_quiet: assert property (held_reset |-> !tdo_oe && !tdo)
        else $error("output active in test reset");
    a_reset_pins_core: assert property (!trst_n && !config_active |->
        pin_out == core_out && pin_oe == core_oe) else $error("pins not from core");
    a_core_in_follows: assert property (pins_still |-> core_in == pin_in)
        else $error("core input not from pin");
    a_tdo_after_fall: assert property (disable iff (!rstn || !trst_n)
        $changed(tdo) |-> after_fall) else $error("data out moved off falling edge");
    a_oe_after_fall: assert property (disable iff (!rstn || !trst_n)
        $changed(tdo_oe) |-> after_fall) else $error("enable moved off falling edge");
    a_still_clock_quiet: assert property (disable iff (!rstn || !trst_n)
        tck_still |-> $stable(tdo) && $stable(tdo_oe)) else $error("output moved, clock idle");
endmodule // bstap_port_checker
bind bstap_port bstap_port_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .tck(tck),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .config_active(config_active),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

/* File: test/bstap_tester.sv */
// External test controller model driving the link
`timescale 1ns/1ps
`default_nettype none
module bstap_tester (
    input wire logic ref_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b0;
    end
    // ****************************************************
    // One test clock period, 320 ns, clock rests low
    // ****************************************************
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge ref_clk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge ref_clk);
        tck <= 1'b1;
        // Undriven line reads back as the inverse of the last bit
        q = tdo_oe ? tdo : ~tdo;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b0;
    endtask
    task automatic walk(input logic [7:0] m, input int n);
        logic q;
        for (int i = 0; i < n; i++) step(m[i], 1'b0, q);
    endtask
    task automatic scan(input logic [31:0] d, input int n, output logic [31:0] q);
        q = 32'h0;
        for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
        walk(8'h01, 2);
    endtask
    task automatic reset_tap;
        walk(8'h1F, 6);
    endtask
    task automatic ir(input logic [3:0] code, output logic [31:0] q);
        walk(8'h03, 4);
        scan({28'h0, code}, 4, q);
    endtask
    task automatic dr(input logic [31:0] d, input int n, output logic [31:0] q);
        walk(8'h01, 3);
        scan(d, n, q);
    endtask
endmodule // bstap_tester
`default_nettype wire

/* File: test/bstap_port_test.sv */
// Self-checking bench of the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.vh"
module bstap_port_test;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic config_active = 1'b0;
    logic [3:0] core_out = 4'h0;
    logic [3:0] core_oe = 4'h0;
    logic [3:0] pin_in = 4'h0;
    wire logic tck, tms, tdi, trst_n, tdo, tdo_oe;
    wire logic [3:0] core_in, pin_out, pin_oe;
    int error_cnt = 0;
    int tests_run = 0;
    logic [31:0] q;
    always #20 ref_clk = ~ref_clk;
    bstap_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .config_active(config_active),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    bstap_tester u_tst (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_idcode;
        check("tdo_oe", tdo_oe, 1'b0);
        u_tst.reset_tap();
        u_tst.dr(32'h0, 32, q);
        check("idcode", q, `BSTAP_IDCODE_VALUE);
        check("idle_oe", tdo_oe, 1'b0);
    endtask
    task automatic t_bypass;
        logic [3:0] codes [2] = '{`BSTAP_OP_BYPASS, 4'h3};
        foreach (codes[i]) begin
            u_tst.ir(codes[i], q);
            check("ir_capture", q[3:0], `BSTAP_IR_CAPTURE);
            u_tst.dr(32'hB5, 8, q);
            check("bypass", q[7:0], 8'h6A);
        end
    endtask
    // Expected patterns assume cell 0 takes the data input and cell 3 drives the data output
    task automatic t_boundary;
        pin_in <= 4'h3;
        core_out <= 4'hC;
        core_oe <= 4'h9;
        u_tst.ir(`BSTAP_OP_SAMPLE, q);
        u_tst.dr(32'h8F1, 12, q);
        check("sample", q[11:0], 12'hD0B);
        check("sample_pins", pin_out, 4'hC);
        u_tst.ir(`BSTAP_OP_EXTEST, q);
        check("ext_out", pin_out, 4'hA);
        check("ext_oe", pin_oe, 4'h6);
        check("ext_in", core_in, 4'h5);
        @(posedge ref_clk) config_active <= 1'b1;
        @(posedge ref_clk);
        check("cfg_oe", pin_oe, 4'h0);
        config_active <= 1'b0;
    endtask
    task automatic t_trst;
        u_tst.walk(8'h01, 3);
        repeat (5) @(posedge ref_clk);
        check("shift_oe", tdo_oe, 1'b1);
        u_tst.trst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("trst_oe", tdo_oe, 1'b0);
        check("trst_pins", pin_out, core_out);
        u_tst.trst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        u_tst.walk(8'h00, 1);
        u_tst.dr(32'h0, 32, q);
        check("trst_ir", q, `BSTAP_IDCODE_VALUE);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        u_tst.trst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_idcode();
        t_bypass();
        t_boundary();
        t_trst();
        u_tst.trst_n <= 1'b0;
        stop_test();
    end
    initial begin
        #2ms;
        error_cnt++;
        stop_test();
    end
endmodule // bstap_port_test
`default_nettype wire
